// *** pd_mac_interrupt_enables.sv ***
/*
 Interrupt enable, frame start status and clock request logic of the PD MAC.
 Assumes the host register port is on clk and that status flags of the
 transmit, receive and receive error groups are held elsewhere.
*/
`timescale 1ns/100ps
`include "pd_irq_defines.svh"

module pd_mac_interrupt_enables (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [15:0] regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regWriteData,
	output logic      [7:0]  regReadData,
	input  wire logic [4:0]  frameStartDetected,
	input  wire logic [7:0]  txStatus,
	input  wire logic [7:0]  rxStatus,
	input  wire logic [7:0]  rxErrorStatus,
	input  wire logic        macIdle,
	input  wire logic        squelchActive,
	input  wire logic        rxActivityPin,
	output logic             frameStartIrq,
	output logic             txIrq,
	output logic             rxIrq,
	output logic             rxErrorIrq,
	output logic             powerIrq,
	output logic             clockStopRequest,
	output logic             clockStartRequest,
	output logic             clockNeeded
);

	////////////////////////////////////////////////////////////////////////////
	// Registers
	pd_irq_pkg::reg_byte_t     txIrqEnable;
	pd_irq_pkg::reg_byte_t     rxIrqEnable;
	pd_irq_pkg::reg_byte_t     rxErrIrqEnable;
	pd_irq_pkg::reg_byte_t     powerIrqMask;
	logic [4:0]                frameStartEventEnable;
	logic [4:0]                frameStartEventStatus;
	logic                      lineActivityWakeFlag;
	logic                      activitySeen;
	pd_irq_pkg::clock_state_e  clockState;
	pd_irq_pkg::clock_state_e  next_clockState;

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	wire selStatus;
	wire selTx;
	wire selRx;
	wire selRxErr;
	wire selPower;
	wire selSopEn;
	assign selStatus = regAddr == `FRAME_START_STATUS_ADDR;
	assign selTx     = regAddr == `TX_IRQ_ENABLE_ADDR;
	assign selRx     = regAddr == `RX_IRQ_ENABLE_ADDR;
	assign selRxErr  = regAddr == `RX_ERR_IRQ_ENABLE_ADDR;
	assign selPower  = regAddr == `POWER_IRQ_MASK_ADDR;
	assign selSopEn  = regAddr == `FRAME_START_ENABLE_ADDR;

	wire wrTx;
	wire wrRx;
	wire wrRxErr;
	wire wrPower;
	wire wrSopEn;
	assign wrTx    = regWrite & selTx;
	assign wrRx    = regWrite & selRx;
	assign wrRxErr = regWrite & selRxErr;
	assign wrPower = regWrite & selPower;
	assign wrSopEn = regWrite & selSopEn;

	////////////////////////////////////////////////////////////////////////////
	// Write-one-to-clear strobes
	wire [7:0] frameStartWriteBits;
	wire [4:0] frameStartClear;
	assign frameStartWriteBits = regWriteData & `FRAME_START_BITS_MASK;
	assign frameStartClear     = (regWrite & selStatus)
		? frameStartWriteBits[4:0] : 5'h00;

	////////////////////////////////////////////////////////////////////////////
	// Enable registers, reserved bits held at zero
	wire [7:0] next_txIrqEnable;
	wire [7:0] next_rxIrqEnable;
	wire [7:0] next_rxErrIrqEnable;
	wire [7:0] next_powerIrqMask;
	wire [4:0] next_frameStartEventEnable;
	assign next_txIrqEnable    = wrTx ? regWriteData & `TX_IRQ_ENABLE_MASK
		: txIrqEnable;
	assign next_rxIrqEnable    = wrRx ? regWriteData & `RX_IRQ_ENABLE_MASK
		: rxIrqEnable;
	assign next_rxErrIrqEnable = wrRxErr ? regWriteData & `RX_ERR_IRQ_ENABLE_MASK
		: rxErrIrqEnable;
	assign next_powerIrqMask   = wrPower ? regWriteData & `POWER_IRQ_MASK_MASK
		: powerIrqMask;
	assign next_frameStartEventEnable = wrSopEn
		? frameStartWriteBits[4:0] : frameStartEventEnable;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txIrqEnable           <= `ENABLE_RESET_VALUE;
			rxIrqEnable           <= `ENABLE_RESET_VALUE;
			rxErrIrqEnable        <= `ENABLE_RESET_VALUE;
			powerIrqMask          <= `ENABLE_RESET_VALUE;
			frameStartEventEnable <= 5'h00;
		end
		else
		begin
			txIrqEnable           <= next_txIrqEnable;
			rxIrqEnable           <= next_rxIrqEnable;
			rxErrIrqEnable        <= next_rxErrIrqEnable;
			powerIrqMask          <= next_powerIrqMask;
			frameStartEventEnable <= next_frameStartEventEnable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power control fields
	wire wakeIrqEnable;
	wire clockStopEnable;
	wire clockStartEnable;
	assign wakeIrqEnable    = powerIrqMask[`POWER_WAKE_IRQ_EN_BIT];
	assign clockStartEnable = powerIrqMask[`POWER_CLK_START_EN_BIT];
	assign clockStopEnable  = powerIrqMask[`POWER_CLK_STOP_EN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Frame start status, set regardless of enables
	frame_start_flags #(
		.WIDTH(`FRAME_START_WIDTH)
	) frameStartFlags (
		.clk      (clk),
		.reset    (reset),
		.setPulse (frameStartDetected),
		.clearBits(frameStartClear),
		.flags    (frameStartEventStatus)
	);

	////////////////////////////////////////////////////////////////////////////
	// Line activity wake flag, cleared here only by reset since its clear strobe is tied to zero
	// The wake status itself lives in the neighbouring status register;
	// its one-to-clear arrives here as a plain strobe, held inactive.
	wire wakeClear;
	wire wakeClearPort;
	assign wakeClear     = regWrite & selPower & 1'b0;
	assign wakeClearPort = wakeClear;

	activity_wake_catcher wakeCatcher (
		.clk         (clk),
		.reset       (reset),
		.activityPin (rxActivityPin),
		.irqEnable   (wakeIrqEnable),
		.clearFlag   (wakeClearPort),
		.activitySeen(activitySeen),
		.wakeFlag    (lineActivityWakeFlag)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interrupt levels
	assign frameStartIrq = |(frameStartEventStatus & frameStartEventEnable);
	assign txIrq         = |(txStatus & txIrqEnable);
	assign rxIrq         = |(rxStatus & rxIrqEnable);
	assign rxErrorIrq    = |(rxErrorStatus & rxErrIrqEnable);
	assign powerIrq      = lineActivityWakeFlag & wakeIrqEnable;

	////////////////////////////////////////////////////////////////////////////
	// Clock request sequencing
	always_comb
	begin
		next_clockState = clockState;
		unique case (clockState)
			pd_irq_pkg::CLK_RUNNING:
				if (macIdle && !squelchActive && clockStopEnable)
					next_clockState = pd_irq_pkg::CLK_STOP_REQUESTED;
			pd_irq_pkg::CLK_STOP_REQUESTED:
				if (squelchActive || !macIdle || !clockStopEnable)
					next_clockState = pd_irq_pkg::CLK_RUNNING;
				else if (activitySeen)
					next_clockState = pd_irq_pkg::CLK_WAKING;
			pd_irq_pkg::CLK_WAKING:
				if (squelchActive || !macIdle || !activitySeen)
					next_clockState = pd_irq_pkg::CLK_RUNNING;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			clockState <= pd_irq_pkg::CLK_RUNNING;
		else
			clockState <= next_clockState;
	end

	// Stop request comes from the state register
	assign clockStopRequest = clockState == pd_irq_pkg::CLK_STOP_REQUESTED;

	// Start request follows the raw pin so it works with the clock stopped
	assign clockStartRequest = clockStartEnable & rxActivityPin;

	// Needed while busy or once squelch is active
	assign clockNeeded = !macIdle || squelchActive;

	////////////////////////////////////////////////////////////////////////////
	// Read data
	wire [7:0] statusRead;
	wire [7:0] readMux;
	assign statusRead = {3'b000, frameStartEventStatus};
	assign readMux =
		selStatus ? statusRead :
		selTx     ? txIrqEnable :
		selRx     ? rxIrqEnable :
		selRxErr  ? rxErrIrqEnable :
		selPower  ? powerIrqMask :
		selSopEn  ? {3'b000, frameStartEventEnable} :
		8'h00;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			regReadData <= `STATUS_RESET_VALUE;
		else if (regRead)
			regReadData <= readMux;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	statusOnlyByHw_a : assert property (@(posedge clk) disable iff (reset)
		(!regWrite || !selStatus) |=>
			((frameStartEventStatus & $past(frameStartEventStatus))
				== $past(frameStartEventStatus)))
		else $error("frame start flag dropped without a clear");

	clearOnOne_a : assert property (@(posedge clk) disable iff (reset)
		(regWrite && selStatus && regWriteData[0] && !frameStartDetected[0])
			|=> !frameStartEventStatus[0])
		else $error("frame start flag not cleared by one");

	setIgnoresEnable_a : assert property (@(posedge clk) disable iff (reset)
		(frameStartDetected[2] && frameStartEventEnable == 5'h00 && !wrSopEn)
			|=> frameStartEventStatus[2] && !frameStartIrq)
		else $error("frame start flag not recorded while disabled");

	sopIrqLevel_a : assert property (@(posedge clk) disable iff (reset)
		frameStartIrq == (|(frameStartEventStatus & frameStartEventEnable)))
		else $error("frame start interrupt level wrong");

	rxMaskReserved_a : assert property (@(posedge clk) disable iff (reset)
		wrRx |=> (rxIrqEnable[4] == 1'b0 && rxIrqEnable[3] == $past(regWriteData[3])))
		else $error("receive mask field wrong");

	errMaskReserved_a : assert property (@(posedge clk) disable iff (reset)
		wrRxErr |=> (rxErrIrqEnable[6:4] == 3'b000
			&& rxErrIrqEnable[7] == $past(regWriteData[7])))
		else $error("receive error mask field wrong");

	powerReserved_a : assert property (@(posedge clk) disable iff (reset)
		wrPower |=> (powerIrqMask[7:4] == 4'h0 && powerIrqMask[1] == 1'b0))
		else $error("power mask reserved bits set");

	txMaskStore_a : assert property (@(posedge clk) disable iff (reset)
		wrTx |=> txIrqEnable == $past(regWriteData)
			##1 ($past(wrTx) || $stable(txIrqEnable)))
		else $error("transmit mask not stored");

	stopRequest_a : assert property (@(posedge clk) disable iff (reset)
		(!clockStopEnable) |=> !clockStopRequest)
		else $error("stop request without enable");

	stopRequestIdle_a : assert property (@(posedge clk) disable iff (reset)
		(clockStopEnable && macIdle && !squelchActive
			&& clockState == pd_irq_pkg::CLK_RUNNING) |=> clockStopRequest)
		else $error("idle MAC did not request clock stop");

	startRequest_a : assert property (@(posedge clk) disable iff (reset)
		(clockStartEnable && rxActivityPin) |-> clockStartRequest)
		else $error("activity did not request clock start");

	squelchNeeds_a : assert property (@(posedge clk) disable iff (reset)
		squelchActive |-> clockNeeded ##1 !clockStopRequest)
		else $error("squelch without clock need");

	idleRelease_a : assert property (@(posedge clk) disable iff (reset)
		(macIdle && !squelchActive) |-> !clockNeeded)
		else $error("idle MAC still needs clock");

	powerIrqLevel_a : assert property (@(posedge clk) disable iff (reset)
		powerIrq == (lineActivityWakeFlag && powerIrqMask[0]))
		else $error("power interrupt level wrong");

endmodule : pd_mac_interrupt_enables

// *** pd_irq_defines.svh ***
/*
 Register offsets, field positions, writable masks and reset values of the
 interrupt enable and power control block.
 Assumes an 8-bit host register port with a 16-bit address.
*/
`ifndef PD_IRQ_DEFINES_SVH
`define PD_IRQ_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define FRAME_START_STATUS_ADDR  16'h1A85
`define TX_IRQ_ENABLE_ADDR       16'h1A86
`define RX_IRQ_ENABLE_ADDR       16'h1A87
`define RX_ERR_IRQ_ENABLE_ADDR   16'h1A88
`define POWER_IRQ_MASK_ADDR      16'h1A89
`define FRAME_START_ENABLE_ADDR  16'h1A8A

////////////////////////////////////////////////////////////////////////////////
// Writable bits; all others are reserved and read as zero
`define FRAME_START_BITS_MASK    8'h1F
`define TX_IRQ_ENABLE_MASK       8'hFF
`define RX_IRQ_ENABLE_MASK       8'hEF
`define RX_ERR_IRQ_ENABLE_MASK   8'h8F
`define POWER_IRQ_MASK_MASK      8'h0D

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FRAME_START_WIDTH        5
`define POWER_WAKE_IRQ_EN_BIT    0
`define POWER_CLK_START_EN_BIT   2
`define POWER_CLK_STOP_EN_BIT    3
`define POWER_WAKE_FLAG_BIT      0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define ENABLE_RESET_VALUE       8'h00
`define STATUS_RESET_VALUE       8'h00

////////////////////////////////////////////////////////////////////////////////
// Timing
`define SYNC_STAGES              3

`endif

// *** pd_irq_pkg.sv ***
/*
 Types shared by the interrupt enable and power control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pd_irq_pkg;

	// Clock request sequencing
	typedef enum logic [1:0]
	{
		CLK_RUNNING,
		CLK_STOP_REQUESTED,
		CLK_WAKING
	} clock_state_e;

	typedef logic [7:0] reg_byte_t;

endpackage : pd_irq_pkg

// *** frame_start_flags.sv ***
/*
 Sticky per-type frame start flags with write-one-to-clear.
 Assumes set pulses and clear strobes are on the clk domain.
*/
`timescale 1ns/100ps

module frame_start_flags #(
	parameter int WIDTH = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] setPulse,
	input  wire logic [WIDTH-1:0] clearBits,
	output logic      [WIDTH-1:0] flags
);

	////////////////////////////////////////////////////////////////////////////
	// One flag per type
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : flagBit
			wire next_flag;
			assign next_flag = setPulse[i] | (flags[i] & ~clearBits[i]);

			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
					flags[i] <= 1'b0;
				else
					flags[i] <= next_flag;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks
	setWinsClear_a : assert property (@(posedge clk) disable iff (reset)
		(|setPulse) |=> ((flags & $past(setPulse)) == $past(setPulse)))
		else $error("frame start set lost");

endmodule : frame_start_flags

// *** activity_wake_catcher.sv ***
/*
 Line activity synchroniser and sticky wake flag.
 Assumes activityPin comes from the line receiver, outside the clk domain.
*/
`timescale 1ns/100ps
`include "pd_irq_defines.svh"

module activity_wake_catcher (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic activityPin,
	input  wire logic irqEnable,
	input  wire logic clearFlag,
	output logic      activitySeen,
	output logic      wakeFlag
);

	logic [`SYNC_STAGES-1:0] syncStage;
	logic                    agreed;

	////////////////////////////////////////////////////////////////////////////
	// Three stages; a change counts once stages two and three agree
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			syncStage <= '0;
		else
			syncStage <= {syncStage[`SYNC_STAGES-2:0], activityPin};
	end

	wire stagesAgree;
	wire risen;
	wire next_agreed;
	wire next_wakeFlag;
	assign stagesAgree   = syncStage[1] == syncStage[2];
	assign next_agreed   = stagesAgree ? syncStage[2] : agreed;
	assign risen         = next_agreed & ~agreed;
	assign next_wakeFlag = (irqEnable & risen) | (wakeFlag & ~clearFlag);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			agreed   <= 1'b0;
			wakeFlag <= 1'b0;
		end
		else
		begin
			agreed   <= next_agreed;
			wakeFlag <= next_wakeFlag;
		end
	end

	assign activitySeen = agreed;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	noWakeDisabled_a : assert property (@(posedge clk) disable iff (reset)
		(!irqEnable && !wakeFlag) |=> !wakeFlag)
		else $error("wake flag set while disabled");

endmodule : activity_wake_catcher

// *** pd_mac_interrupt_enables_tb.sv ***
/*
 Self-checking testbench of the interrupt enable and power control block.
 Assumes the register defines header is on the include path.
*/
`timescale 1ns/100ps
`include "pd_irq_defines.svh"

module pd_mac_interrupt_enables_tb;

	logic        clk;
	logic        reset;
	logic [15:0] regAddr;
	logic        regWrite;
	logic        regRead;
	logic [7:0]  regWriteData;
	logic [7:0]  regReadData;
	logic [4:0]  frameStartDetected;
	logic [7:0]  txStatus;
	logic [7:0]  rxStatus;
	logic [7:0]  rxErrorStatus;
	logic        macIdle;
	logic        squelchActive;
	logic        rxActivityPin;
	logic        frameStartIrq;
	logic        txIrq;
	logic        rxIrq;
	logic        rxErrorIrq;
	logic        powerIrq;
	logic        clockStopRequest;
	logic        clockStartRequest;
	logic        clockNeeded;
	int          errTotal;
	int          nChecks;

	pd_mac_interrupt_enables dut_u (
		.clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData),
		.frameStartDetected(frameStartDetected), .txStatus(txStatus),
		.rxStatus(rxStatus), .rxErrorStatus(rxErrorStatus), .macIdle(macIdle),
		.squelchActive(squelchActive), .rxActivityPin(rxActivityPin),
		.frameStartIrq(frameStartIrq), .txIrq(txIrq), .rxIrq(rxIrq),
		.rxErrorIrq(rxErrorIrq), .powerIrq(powerIrq),
		.clockStopRequest(clockStopRequest), .clockStartRequest(clockStartRequest),
		.clockNeeded(clockNeeded)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access and checking tasks
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expd);
		nChecks++;
		if (seen !== expd)
		begin
			$display("wrong value %s expected %h seen %h", name, expd, seen);
			errTotal++;
		end
	endtask : check

	task automatic regWr(input logic [15:0] addr, input logic [7:0] data);
		@(negedge clk);
		regAddr = addr;
		regWriteData = data;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 1'b0;
	endtask : regWr

	task automatic regRd(input logic [15:0] addr, output logic [7:0] data);
		@(negedge clk);
		regAddr = addr;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		data = regReadData;
	endtask : regRd

	task automatic stopTest;
		$display("checks %0d mismatches %0d", nChecks, errTotal);
		if (errTotal == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stopTest

	// Bounded wait for clockStopRequest (sel 0) or powerIrq (sel 1) to reach lvl
	task automatic waitLevel(input int sel, input logic lvl);
		int n;
		n = 0;
		while (((sel == 0) ? clockStopRequest : powerIrq) !== lvl && n < 12)
		begin
			@(negedge clk);
			n++;
		end
		if (((sel == 0) ? clockStopRequest : powerIrq) !== lvl)
		begin
			$display("wrong value wait %0d expected %b seen timeout", sel, lvl);
			errTotal++;
			stopTest();
		end
	endtask : waitLevel

	////////////////////////////////////////////////////////////////////////////////
	// Test sequence
	logic [15:0] addrTab [0:5];
	logic [7:0]  maskTab [0:5];
	logic [7:0]  rd;
	logic        irq;

	initial
	begin
		addrTab = '{`FRAME_START_STATUS_ADDR, `TX_IRQ_ENABLE_ADDR, `RX_IRQ_ENABLE_ADDR,
			`RX_ERR_IRQ_ENABLE_ADDR, `POWER_IRQ_MASK_ADDR, `FRAME_START_ENABLE_ADDR};
		maskTab = '{8'h00, 8'hFF, 8'hEF, 8'h8F, 8'h0D, 8'h1F};
		errTotal = 0;
		nChecks = 0;
		reset = 1'b1;
		regAddr = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWriteData = 8'h00;
		frameStartDetected = 5'h00;
		txStatus = 8'h00;
		rxStatus = 8'h00;
		rxErrorStatus = 8'h00;
		macIdle = 1'b0;
		squelchActive = 1'b0;
		rxActivityPin = 1'b0;
		repeat (5) @(negedge clk);
		reset = 1'b0;

		// Reset values, writable bits and unmapped place
		for (int r = 0; r < 6; r++)
		begin
			regRd(addrTab[r], rd);
			check("reset value", rd, 8'h00);
			regWr(addrTab[r], 8'hFF);
			regRd(addrTab[r], rd);
			check("writable bits", rd, maskTab[r]);
			regWr(addrTab[r], 8'h00);
		end
		regWr(16'h1A8F, 8'hFF);
		regRd(16'h1A8F, rd);
		check("unmapped", rd, 8'h00);
		$display("test registers done");

		// Enable mapping per bit of the three outside groups
		for (int g = 1; g < 4; g++)
			for (int i = 0; i < 8; i++)
			begin
				regWr(addrTab[g], 8'h01 << i);
				txStatus = (g == 1) ? ~(8'h01 << i) : 8'h00;
				rxStatus = (g == 2) ? ~(8'h01 << i) : 8'h00;
				rxErrorStatus = (g == 3) ? ~(8'h01 << i) : 8'h00;
				@(negedge clk);
				irq = (g == 1) ? txIrq : (g == 2) ? rxIrq : rxErrorIrq;
				check("irq other bits", {7'h00, irq}, 8'h00);
				txStatus = (g == 1) ? (8'h01 << i) : 8'h00;
				rxStatus = (g == 2) ? (8'h01 << i) : 8'h00;
				rxErrorStatus = (g == 3) ? (8'h01 << i) : 8'h00;
				@(negedge clk);
				irq = (g == 1) ? txIrq : (g == 2) ? rxIrq : rxErrorIrq;
				check("irq own bit", {7'h00, irq}, {7'h00, maskTab[g][i]});
				regWr(addrTab[g], 8'h00);
				irq = (g == 1) ? txIrq : (g == 2) ? rxIrq : rxErrorIrq;
				check("irq disabled", {7'h00, irq}, 8'h00);
			end
		txStatus = 8'h00;
		rxStatus = 8'h00;
		rxErrorStatus = 8'h00;
		$display("test group enables done");

		// Frame start flags per type, receive group fully enabled
		regWr(`RX_IRQ_ENABLE_ADDR, 8'hFF);
		for (int i = 0; i < 5; i++)
		begin
			@(negedge clk);
			frameStartDetected = 5'h01 << i;
			@(negedge clk);
			frameStartDetected = 5'h00;
			regRd(`FRAME_START_STATUS_ADDR, rd);
			check("frame status set", rd, 8'h01 << i);
			check("frame irq masked", {7'h00, frameStartIrq}, 8'h00);
			regWr(`FRAME_START_ENABLE_ADDR, 8'h01 << i);
			check("frame irq", {7'h00, frameStartIrq}, 8'h01);
			check("rx irq quiet", {7'h00, rxIrq}, 8'h00);
			regWr(`FRAME_START_STATUS_ADDR, ~(8'h01 << i));
			regRd(`FRAME_START_STATUS_ADDR, rd);
			check("frame zero write", rd, 8'h01 << i);
			regWr(`FRAME_START_STATUS_ADDR, 8'h01 << i);
			regRd(`FRAME_START_STATUS_ADDR, rd);
			check("frame clear", rd, 8'h00);
			check("frame irq off", {7'h00, frameStartIrq}, 8'h00);
			regWr(`FRAME_START_ENABLE_ADDR, 8'h00);
		end
		regWr(`RX_IRQ_ENABLE_ADDR, 8'h00);
		$display("test frame start done");

		// Clock requests and wake flag
		regWr(`POWER_IRQ_MASK_ADDR, 8'h0C);
		rxActivityPin = 1'b1;
		@(negedge clk);
		check("start request", {7'h00, clockStartRequest}, 8'h01);
		repeat (8) @(negedge clk);
		check("wake blocked", {7'h00, powerIrq}, 8'h00);
		rxActivityPin = 1'b0;
		@(negedge clk);
		check("start request off", {7'h00, clockStartRequest}, 8'h00);
		regWr(`POWER_IRQ_MASK_ADDR, 8'h0D);
		check("wake not latched", {7'h00, powerIrq}, 8'h00);
		macIdle = 1'b1;
		@(negedge clk);
		check("clock not needed", {7'h00, clockNeeded}, 8'h00);
		waitLevel(0, 1'b1);
		squelchActive = 1'b1;
		@(negedge clk);
		check("clock needed squelch", {7'h00, clockNeeded}, 8'h01);
		waitLevel(0, 1'b0);
		squelchActive = 1'b0;
		waitLevel(0, 1'b1);
		regWr(`POWER_IRQ_MASK_ADDR, 8'h00);
		waitLevel(0, 1'b0);
		check("clock not needed", {7'h00, clockNeeded}, 8'h00);
		macIdle = 1'b0;
		regWr(`POWER_IRQ_MASK_ADDR, 8'h0D);
		rxActivityPin = 1'b1;
		waitLevel(1, 1'b1);
		rxActivityPin = 1'b0;
		regWr(`POWER_IRQ_MASK_ADDR, 8'h01);
		check("wake kept", {7'h00, powerIrq}, 8'h01);
		regWr(`POWER_IRQ_MASK_ADDR, 8'h00);
		check("wake masked", {7'h00, powerIrq}, 8'h00);
		$display("test power done");
		stopTest();
	end

endmodule : pd_mac_interrupt_enables_tb
